// file: imp_pkg.sv
/*
  shared constants and carrier types for the mtp programming-access block.
  assumes a 200 MHz system clock and three 256-byte address spaces.
*/
`default_nettype none
package imp_pkg;
  localparam int unsigned SYS_CLK_PERIOD_NS = 5;
  localparam int unsigned ERASE_CYCLE_TIME_MS = 20;
  localparam int unsigned ERASE_CYCLE_CYCLES = ERASE_CYCLE_TIME_MS * 1000000 / SYS_CLK_PERIOD_NS;
  localparam int unsigned SPACE_BYTES = 256;
  localparam int unsigned PAGE_BYTES = 16;
  localparam logic [7:0] OFS_ADDR_CODE = 8'h7F;
  localparam logic [7:0] ADDR_CODE_RESET = 8'h01;
  localparam logic [7:0] OFS_REG_PROT = 8'hE0;
  localparam logic [7:0] OFS_CFG_PROT = 8'hE1;
  localparam logic [7:0] OFS_EE_PROT = 8'hE2;
  localparam logic [7:0] OFS_ERASE = 8'hE3;
  localparam logic [7:0] OFS_PROT_LOCK = 8'hE4;
  localparam logic [7:0] OFS_CHIP_ERASE = 8'hE5;
  localparam int unsigned CHIP_SEL_BIT = 0;
  localparam int unsigned CHIP_DIS_BIT = 1;
  localparam int unsigned EE_WP_EN_BIT = 2;
  localparam int unsigned PROT_LOCK_BIT = 0;
  localparam int unsigned CFG_RD_BLK_BIT = 0;
  localparam int unsigned CFG_WR_BLK_BIT = 1;
  localparam logic [2:0] BLK_REG = 3'h0;
  localparam logic [2:0] BLK_CFG = 3'h2;
  localparam logic [2:0] BLK_EE = 3'h3;
  localparam logic [2:0] ERASE_GO = 3'h6;
  localparam logic [1:0] PROT_NONE = 2'h0;
  localparam logic [1:0] PROT_PART = 2'h1;

  typedef struct packed {
    logic [3:0] code;
    logic [2:0] blk;
    logic rd;
  } imp_ctrl_byte_t;

  typedef struct packed {
    logic [2:0] launch;
    logic ee_sel;
    logic [3:0] page;
  } imp_erase_ctrl_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic rheo_dis;
    logic [1:0] wr;
    logic [1:0] rd;
  } imp_reg_prot_t;
endpackage : imp_pkg
`default_nettype wire

// file: imp_sync.sv
/*
  two-flop level synchroniser, one per bit.
  assumes the input is quasi-static relative to the destination clock.
*/
`timescale 1ns/100ps
`default_nettype none
module imp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : imp_sync
`default_nettype wire

// file: imp_cycle_timer.sv
/*
  self-timed write/erase cycle counter in the system clock domain.
  assumes start_i is a one-cycle pulse; starts while busy are dropped.
*/
`timescale 1ns/100ps
`default_nettype none
module imp_cycle_timer #(
  parameter int unsigned CYCLES = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic busy_d, done_d;

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_o;
    done_d = 1'b0;
    if (start_i && !busy_o) begin
      busy_d = 1'b1;
      cnt_d = CW'(CYCLES - 1);
    end else if (busy_o) begin
      if (cnt_q == '0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_o <= busy_d;
      done_o <= done_d;
    end
  end
endmodule : imp_cycle_timer
`default_nettype wire

// file: imp_mtp_access.sv
/*
  i2c slave access to register, configuration and eeprom spaces of an mtp device.
  assumes clk_link_i oversamples scl/sda at least 8x; timer runs on clk_sys_i.
*/
// Function
// [R1] first four control bits select the device
// [R2] each code bit from register or pin
// [R3] reset code 0001 from internal bits
// [R4] next three bits are block address
// [R5] blocks 000, 010, 011 used; others unused
// [R6] last bit read/write; control byte acknowledged
// [R7] page write acks address and sixteen bytes
// [R8] stop launches timed programming cycle
// [R9] register space served during busy cycle
// [R10] repeated start keeps loaded word address
// [R11] read sends bytes while master acks
// [R12] erase register at word 0xE3
// [R13] bit4 picks array, low nibble page
// [R14] launch bits 110 start timed erase
// [R15] chip select erases whole array unless disabled
// [R16] erase starts at the stop
// [R17] launch bits self-clear after erase
// [R18] address is block plus word byte
// [R19] spaces are sixteen pages of sixteen
// [R20] reset copies configuration into registers
// [R21] protection bytes read live at block 000
// [R22] live protection volatile, stored needs reload
// [R23] register protection gates access and rheostat
// [R24] rheostat disable, write and read fields
// [R25] configuration protection blocks read or write
// [R26] busy arrays refuse new accesses
`timescale 1ns/100ps
`default_nettype none
module imp_mtp_access #(
  parameter int unsigned PROG_CYCLES = imp_pkg::ERASE_CYCLE_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_link_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_pin_one_i,
  input wire logic addr_pin_two_i,
  input wire logic addr_pin_three_i,
  input wire logic addr_pin_four_i,
  input wire logic reload_i,
  input wire logic rheostat_store_i,
  output logic rheostat_store_o,
  output logic cycle_busy_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_CTRL, ST_WADDR, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK, ST_IGNORE
  } imp_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, link domain
  logic [7:0] pins_s;
  logic scl_s, sda_s, reload_s, rheo_s;
  logic [3:0] pin_code_s;
  logic done_tgl_s;

  imp_sync #(.W(8), .RST_VAL(8'h03)) u_pin_sync (
    .clk_i(clk_link_i),
    .rst_n_i(rst_n_i),
    .d_i({rheostat_store_i, reload_i, addr_pin_four_i, addr_pin_three_i,
          addr_pin_two_i, addr_pin_one_i, sda_i, scl_i}),
    .q_o(pins_s)
  );
  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign pin_code_s = pins_s[5:2];
  assign reload_s = pins_s[6];
  assign rheo_s = pins_s[7];

  ////////////////////////////////////////////////////////////////////////////////
  // system domain: cycle timer and start toggle crossing; done toggle synchronised on clk_link_i
  logic start_tgl_q, start_tgl_s, start_p_q, start_p_d, done_tgl_q, done_tgl_d;
  logic tmr_done, tmr_start;

  imp_sync #(.W(1), .RST_VAL(1'b0)) u_start_sync (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i(start_tgl_q),
    .q_o(start_tgl_s)
  );
  imp_sync #(.W(1), .RST_VAL(1'b0)) u_done_sync (
    .clk_i(clk_link_i),
    .rst_n_i(rst_n_i),
    .d_i(done_tgl_q),
    .q_o(done_tgl_s)
  );
  imp_cycle_timer #(.CYCLES(PROG_CYCLES)) u_timer (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .start_i(tmr_start),
    .busy_o(cycle_busy_o),
    .done_o(tmr_done)
  );

  always_comb begin
    tmr_start = start_tgl_s ^ start_p_q; // [R8] [R16]
    start_p_d = start_tgl_s;
    done_tgl_d = done_tgl_q ^ tmr_done;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_p_q <= 1'b0;
      done_tgl_q <= 1'b0;
    end else begin
      start_p_q <= start_p_d;
      done_tgl_q <= done_tgl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link domain state
  imp_state_t st_q, st_d, nxt_q, nxt_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, addr_q, addr_d;
  imp_pkg::imp_ctrl_byte_t ctrl_q, ctrl_d;
  logic ack_q, ack_d, ph_q, ph_d, oe_q, oe_d;
  logic scl_p_q, sda_p_q, reload_p_q, done_p_q;
  logic [7:0] buf_q [imp_pkg::PAGE_BYTES];
  logic [7:0] buf_d [imp_pkg::PAGE_BYTES];
  logic [15:0] bmask_q, bmask_d;
  logic [3:0] bpage_q, bpage_d;
  logic bee_q, bee_d, pend_prog_q, pend_prog_d, pend_er_q, pend_er_d;
  logic busy_q, busy_d, op_er_q, op_er_d, tgl_d, rheo_d;
  imp_pkg::imp_erase_ctrl_t er_q, er_d;
  logic chip_q, chip_d;
  logic [8:0] ld_q, ld_d;
  logic [7:0] reg_q [imp_pkg::SPACE_BYTES];
  logic [7:0] reg_d [imp_pkg::SPACE_BYTES];
  logic [7:0] cfg_q [imp_pkg::SPACE_BYTES];
  logic [7:0] cfg_d [imp_pkg::SPACE_BYTES];
  logic [7:0] ee_q [imp_pkg::SPACE_BYTES];
  logic [7:0] ee_d [imp_pkg::SPACE_BYTES];

  logic scl_rise, scl_fall, start_c, stop_c, done_c;
  logic [7:0] byte_c, rd_byte, code_cfg;
  logic [3:0] code_eff;
  imp_pkg::imp_ctrl_byte_t cb;
  imp_pkg::imp_reg_prot_t rprot;
  logic [7:0] cfg_prot, ee_prot;
  logic protection_lock, blk_ok, refuse, wr_ok, ee_page_lock, er_lock;
  imp_pkg::imp_erase_ctrl_t er_now;

  always_comb begin
    scl_rise = scl_s & ~scl_p_q;
    scl_fall = ~scl_s & scl_p_q;
    start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
    stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
    done_c = done_tgl_s ^ done_p_q;
    byte_c = {sh_q[6:0], sda_s};
    cb = imp_pkg::imp_ctrl_byte_t'(byte_c);
    code_cfg = reg_q[imp_pkg::OFS_ADDR_CODE];
    for (int i = 0; i < 4; i++) begin
      code_eff[i] = code_cfg[4 + i] ? pin_code_s[i] : code_cfg[i]; // [R2] [R3]
    end
    rprot = imp_pkg::imp_reg_prot_t'(reg_q[imp_pkg::OFS_REG_PROT]); // [R22] [R24]
    cfg_prot = reg_q[imp_pkg::OFS_CFG_PROT];
    ee_prot = reg_q[imp_pkg::OFS_EE_PROT];
    protection_lock = reg_q[imp_pkg::OFS_PROT_LOCK][imp_pkg::PROT_LOCK_BIT];
    blk_ok = (cb.blk == imp_pkg::BLK_REG) || (cb.blk == imp_pkg::BLK_CFG)
             || (cb.blk == imp_pkg::BLK_EE); // [R5]
    refuse = (busy_q && cb.blk != imp_pkg::BLK_REG) // [R9] [R26]
             || (cb.blk == imp_pkg::BLK_CFG && cb.rd && cfg_prot[imp_pkg::CFG_RD_BLK_BIT])
             || (cb.blk == imp_pkg::BLK_CFG && !cb.rd
                 && cfg_prot[imp_pkg::CFG_WR_BLK_BIT]); // [R25]
    wr_ok = (rprot.wr == imp_pkg::PROT_NONE || (rprot.wr == imp_pkg::PROT_PART && addr_q[7]))
            && !(protection_lock && addr_q >= imp_pkg::OFS_REG_PROT && addr_q <= imp_pkg::OFS_EE_PROT);
    ee_page_lock = ee_prot[imp_pkg::EE_WP_EN_BIT] && (bpage_q[3:2] >= (2'h3 - ee_prot[1:0]));
    er_now = imp_pkg::imp_erase_ctrl_t'(reg_q[imp_pkg::OFS_ERASE]);
    er_lock = er_now.ee_sel ? (ee_prot[imp_pkg::EE_WP_EN_BIT]
                               && (er_now.page[3:2] >= (2'h3 - ee_prot[1:0])))
                            : cfg_prot[imp_pkg::CFG_WR_BLK_BIT];
    rd_byte = 8'h00;
    case (ctrl_q.blk)
      imp_pkg::BLK_REG: begin
        if (rprot.rd == imp_pkg::PROT_NONE || (rprot.rd == imp_pkg::PROT_PART && addr_q[7])) begin
          rd_byte = reg_q[addr_q]; // [R21] [R23]
        end
      end
      imp_pkg::BLK_CFG: rd_byte = cfg_q[addr_q];
      imp_pkg::BLK_EE: rd_byte = ee_q[addr_q];
      default: rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link domain next state
  always_comb begin
    st_d = st_q;
    nxt_d = nxt_q;
    bit_d = bit_q;
    sh_d = sh_q;
    addr_d = addr_q;
    ctrl_d = ctrl_q;
    ack_d = ack_q;
    ph_d = ph_q;
    oe_d = oe_q;
    buf_d = buf_q;
    bmask_d = bmask_q;
    bpage_d = bpage_q;
    bee_d = bee_q;
    pend_prog_d = pend_prog_q;
    pend_er_d = pend_er_q;
    busy_d = busy_q;
    op_er_d = op_er_q;
    er_d = er_q;
    chip_d = chip_q;
    tgl_d = start_tgl_q;
    ld_d = ld_q;
    reg_d = reg_q;
    cfg_d = cfg_q;
    ee_d = ee_q;
    rheo_d = rheo_s & ~rprot.rheo_dis; // [R23] [R24]
    if (done_c) begin
      busy_d = 1'b0;
      if (op_er_q) begin
        for (int i = 0; i < imp_pkg::SPACE_BYTES; i++) begin
          if (chip_q) begin
            cfg_d[i] = 8'hFF; // [R15]
            ee_d[i] = 8'hFF;
          end else if (i[7:4] == er_q.page) begin
            if (er_q.ee_sel) ee_d[i] = 8'hFF; // [R13] [R19]
            else cfg_d[i] = 8'hFF;
          end
        end
        reg_d[imp_pkg::OFS_ERASE][7:5] = 3'h0; // [R17]
      end else begin
        for (int i = 0; i < imp_pkg::PAGE_BYTES; i++) begin
          if (bmask_q[i]) begin
            if (bee_q) ee_d[{bpage_q, 4'(i)}] = buf_q[i]; // [R19]
            else cfg_d[{bpage_q, 4'(i)}] = buf_q[i];
          end
        end
      end
    end
    if (reload_s && !reload_p_q) ld_d = 9'h000;
    if (!ld_q[8]) begin
      reg_d[ld_q[7:0]] = cfg_q[ld_q[7:0]]; // [R20] [R22]
      ld_d = ld_q + 9'h001;
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (stop_c) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
      pend_er_d = 1'b0;
      pend_prog_d = 1'b0;
      if (!busy_q && pend_er_q) begin
        if (er_lock) begin
          reg_d[imp_pkg::OFS_ERASE][7:5] = 3'h0;
        end else begin
          busy_d = 1'b1; // [R14] [R16]
          op_er_d = 1'b1;
          er_d = er_now;
          chip_d = reg_q[imp_pkg::OFS_CHIP_ERASE][imp_pkg::CHIP_SEL_BIT]
                   & ~reg_q[imp_pkg::OFS_CHIP_ERASE][imp_pkg::CHIP_DIS_BIT]; // [R15]
          tgl_d = ~start_tgl_q;
        end
      end else if (!busy_q && pend_prog_q && bmask_q != 16'h0000
                   && !(bee_q && ee_page_lock)) begin
        busy_d = 1'b1; // [R8]
        op_er_d = 1'b0;
        tgl_d = ~start_tgl_q;
      end
    end else if (start_c) begin
      st_d = ST_CTRL; // [R10]
      bit_d = 3'h0;
      oe_d = 1'b0;
      pend_er_d = 1'b0;
      pend_prog_d = 1'b0;
      if (!busy_q) bmask_d = 16'h0000;
    end else begin
      case (st_q)
        ST_CTRL, ST_WADDR, ST_WDATA: begin
          if (scl_rise) begin
            sh_d = byte_c;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              ack_d = 1'b1;
              ph_d = 1'b0;
              st_d = ST_ACK;
              case (st_q)
                ST_CTRL: begin
                  if (cb.code == code_eff && blk_ok && !refuse) begin // [R1] [R4] [R6]
                    ctrl_d = cb;
                    nxt_d = cb.rd ? ST_RDATA : ST_WADDR; // [R6] [R11]
                  end else begin
                    st_d = ST_IGNORE;
                  end
                end
                ST_WADDR: begin
                  addr_d = byte_c; // [R10] [R18]
                  nxt_d = ST_WDATA; // [R7]
                  if (ctrl_q.blk != imp_pkg::BLK_REG) begin
                    bpage_d = byte_c[7:4];
                    bmask_d = 16'h0000;
                    bee_d = (ctrl_q.blk == imp_pkg::BLK_EE);
                  end
                end
                default: begin
                  nxt_d = ST_WDATA; // [R7]
                  if (ctrl_q.blk == imp_pkg::BLK_REG) begin
                    addr_d = addr_q + 8'h01;
                    if (wr_ok) begin
                      reg_d[addr_q] = byte_c; // [R22] [R23]
                      if (addr_q == imp_pkg::OFS_ERASE && byte_c[7:5] == imp_pkg::ERASE_GO
                          && !busy_q) begin
                        pend_er_d = 1'b1; // [R12] [R14]
                      end
                    end
                  end else begin
                    buf_d[addr_q[3:0]] = byte_c; // [R19]
                    bmask_d[addr_q[3:0]] = 1'b1;
                    pend_prog_d = 1'b1;
                    addr_d = {addr_q[7:4], addr_q[3:0] + 4'h1};
                  end
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (!ph_q) begin
              oe_d = 1'b1; // [R6] [R7]
              ph_d = 1'b1;
            end else begin
              ph_d = 1'b0;
              bit_d = 3'h0;
              st_d = nxt_q;
              oe_d = 1'b0;
              if (nxt_q == ST_RDATA) begin
                sh_d = rd_byte;
                oe_d = ~rd_byte[7];
              end
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_q == 3'h7) begin
              oe_d = 1'b0;
              st_d = ST_RACK;
              addr_d = addr_q + 8'h01; // [R11]
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
              bit_d = bit_q + 3'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) ack_d = ~sda_s;
          if (scl_fall) begin
            if (ack_q) begin
              sh_d = rd_byte; // [R11]
              oe_d = ~rd_byte[7];
              bit_d = 3'h0;
              st_d = ST_RDATA;
            end else begin
              st_d = ST_IGNORE;
            end
          end
        end
        ST_IGNORE, ST_IDLE: oe_d = 1'b0;
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= ST_IDLE;
      nxt_q <= ST_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      addr_q <= 8'h00;
      ctrl_q <= '0;
      ack_q <= 1'b0;
      ph_q <= 1'b0;
      oe_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      reload_p_q <= 1'b0;
      done_p_q <= 1'b0;
      bmask_q <= 16'h0000;
      bpage_q <= 4'h0;
      bee_q <= 1'b0;
      pend_prog_q <= 1'b0;
      pend_er_q <= 1'b0;
      busy_q <= 1'b0;
      op_er_q <= 1'b0;
      er_q <= '0;
      chip_q <= 1'b0;
      start_tgl_q <= 1'b0;
      ld_q <= 9'h000;
      rheostat_store_o <= 1'b0;
      for (int i = 0; i < imp_pkg::PAGE_BYTES; i++) buf_q[i] <= 8'h00;
      for (int i = 0; i < imp_pkg::SPACE_BYTES; i++) begin
        reg_q[i] <= 8'h00;
        cfg_q[i] <= 8'h00;
        ee_q[i] <= 8'h00;
      end
      reg_q[imp_pkg::OFS_ADDR_CODE] <= imp_pkg::ADDR_CODE_RESET; // [R3]
      cfg_q[imp_pkg::OFS_ADDR_CODE] <= imp_pkg::ADDR_CODE_RESET;
    end else begin
      st_q <= st_d;
      nxt_q <= nxt_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      ctrl_q <= ctrl_d;
      ack_q <= ack_d;
      ph_q <= ph_d;
      oe_q <= oe_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      reload_p_q <= reload_s;
      done_p_q <= done_tgl_s;
      buf_q <= buf_d;
      bmask_q <= bmask_d;
      bpage_q <= bpage_d;
      bee_q <= bee_d;
      pend_prog_q <= pend_prog_d;
      pend_er_q <= pend_er_d;
      busy_q <= busy_d;
      op_er_q <= op_er_d;
      er_q <= er_d;
      chip_q <= chip_d;
      start_tgl_q <= tgl_d;
      ld_q <= ld_d;
      rheostat_store_o <= rheo_d;
      reg_q <= reg_d;
      cfg_q <= cfg_d;
      ee_q <= ee_d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_q;
endmodule : imp_mtp_access
`default_nettype wire

// file: imp_mtp_access_checker.sv
/*
  port-level checks for the mtp access block.
  assumes it is bound onto imp_mtp_access with the same cycle count.
*/
`timescale 1ns/100ps
`default_nettype none
module imp_mtp_access_checker #(
  parameter int unsigned PROG_CYCLES = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_link_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic rheostat_store_i,
  input wire logic rheostat_store_o,
  input wire logic cycle_busy_o
);
  logic [31:0] busy_cnt_q;
  logic [31:0] busy_cnt_d;
  always_comb begin
    busy_cnt_d = cycle_busy_o ? busy_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_busy_rise;
    $rose(cycle_busy_o);
  endsequence
  sequence s_busy_fall;
    $fell(cycle_busy_o);
  endsequence
  property p_busy_min;
    @(posedge clk_sys_i) disable iff (!rst_n_i) s_busy_rise |-> cycle_busy_o [*8];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy pulse too short");
  property p_busy_max;
    @(posedge clk_sys_i) disable iff (!rst_n_i) busy_cnt_q <= PROG_CYCLES + 1;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy pulse too long");
  property p_busy_len;
    @(posedge clk_sys_i) disable iff (!rst_n_i) s_busy_fall |-> busy_cnt_q >= PROG_CYCLES - 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy ended early");
  property p_busy_gap;
    @(posedge clk_sys_i) disable iff (!rst_n_i) s_busy_fall |-> !cycle_busy_o [*3];
  endproperty
  a_busy_gap: assert property (p_busy_gap) else $error("busy restarted at once");
  property p_oe_scl_low;
    @(posedge clk_link_i) disable iff (!rst_n_i) $changed(sda_oe_o) |-> !scl_i;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved, scl high");
  property p_oe_hold;
    @(posedge clk_link_i) disable iff (!rst_n_i) $rose(sda_oe_o) |-> sda_oe_o [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("sda drive too short");
  property p_rheo_src;
    @(posedge clk_link_i) disable iff (!rst_n_i) rheostat_store_o |->
      $past(rheostat_store_i, 2) || $past(rheostat_store_i, 3) || $past(rheostat_store_i, 4);
  endproperty
  a_rheo_src: assert property (p_rheo_src) else $error("store without request");
  property p_sda_low;
    @(posedge clk_link_i) disable iff (!rst_n_i) sda_o == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda drive not low");
endmodule : imp_mtp_access_checker

bind imp_mtp_access imp_mtp_access_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_link_i(clk_link_i), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .rheostat_store_i(rheostat_store_i),
  .rheostat_store_o(rheostat_store_o), .cycle_busy_o(cycle_busy_o));
`default_nettype wire

// file: imp_i2c_master_model.sv
/*
  behavioural i2c bus master for the mtp access block.
  assumes a pull-up on sda and that only this model drives scl.
*/
`timescale 1ns/100ps
`default_nettype none
module imp_i2c_master_model (
  input wire logic clk_link_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_drv_o
);
  initial begin
    scl_o = 1'b1;
    sda_drv_o = 1'b1;
  end
  task automatic w;
    repeat (4) @(posedge clk_link_i);
  endtask : w
  // sda only moves while scl is low, except in start and stop
  task automatic start;
    w();
    sda_drv_o <= 1'b1;
    w();
    scl_o <= 1'b1;
    w();
    sda_drv_o <= 1'b0;
    w();
    scl_o <= 1'b0;
  endtask : start
  task automatic stop;
    w();
    sda_drv_o <= 1'b0;
    w();
    scl_o <= 1'b1;
    w();
    sda_drv_o <= 1'b1;
    w();
  endtask : stop
  task automatic clk_bit(input logic b, output logic s);
    w();
    sda_drv_o <= b;
    w();
    scl_o <= 1'b1;
    w();
    s = sda_i;
    w();
    scl_o <= 1'b0;
  endtask : clk_bit
  // msb first, ninth bit is the acknowledge slot
  task automatic xbyte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
      output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], s);
      rx[i] = s;
    end
    clk_bit(ack_in, s);
    acked = ~s;
  endtask : xbyte
endmodule : imp_i2c_master_model
`default_nettype wire

// file: imp_mtp_access_tb.sv
/*
  self-checking bench for the mtp access block.
  assumes package, design, checker and master model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module imp_mtp_access_tb;
  localparam int unsigned PROG = 4000;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] pins = 4'h0;
  logic reload = 1'b0;
  logic rstore = 1'b0;
  logic scl;
  logic sda_m;
  logic sda_w;
  logic sda_oe;
  logic rheo_o;
  logic busy;
  logic [3:0] code = 4'h1;
  logic [7:0] dbuf [16];
  logic [7:0] ebuf [16];
  logic [7:0] rx;
  logic ak;
  int fail_count = 0;
  int n_compared = 0;
  logic [8:0] rows [9] = '{9'h110, 9'h012, 9'h114, 9'h116, 9'h018, 9'h01A, 9'h01C, 9'h01E,
    9'h020};
  always #2.5 clk_sys = ~clk_sys;
  always #24 clk_link = ~clk_link;
  assign sda_w = sda_m & ~sda_oe;
  imp_mtp_access #(.PROG_CYCLES(PROG)) uut (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .clk_link_i(clk_link), .scl_i(scl),
    .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .addr_pin_one_i(pins[0]),
    .addr_pin_two_i(pins[1]), .addr_pin_three_i(pins[2]), .addr_pin_four_i(pins[3]),
    .reload_i(reload), .rheostat_store_i(rstore), .rheostat_store_o(rheo_o),
    .cycle_busy_o(busy));
  imp_i2c_master_model mst (.clk_link_i(clk_link), .sda_i(sda_w), .scl_o(scl),
    .sda_drv_o(sda_m));
  ////////////////////////////////////////////////////////////////
  task automatic cmp_bit(input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: exp %h got %h", $time, e, g);
    end
  endtask : cmp_bit
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: exp %h got %h", $time, e, g);
    end
  endtask : cmp_byte
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic link_wait(input int n);
    repeat (n) @(posedge clk_link);
  endtask : link_wait
  task automatic wait_busy(input logic v, input int lim);
    int k = 0;
    while (busy !== v && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
    if (busy !== v) begin
      fail_count++;
      give_verdict();
    end
  endtask : wait_busy
  task automatic send(input logic [7:0] b, input logic ex);
    mst.xbyte(b, 1'b1, rx, ak);
    cmp_bit(ex, ak);
  endtask : send
  task automatic ctl(input logic [7:0] b, input logic ex);
    mst.start();
    send(b, ex);
    mst.stop();
  endtask : ctl
  task automatic wr_seq(input logic [2:0] blk, input logic [7:0] addr, input int n);
    mst.start();
    send({code, blk, 1'b0}, 1'b1);
    send(addr, 1'b1);
    for (int i = 0; i < n; i++) begin
      send(dbuf[i], 1'b1);
    end
    mst.stop();
  endtask : wr_seq
  task automatic rd_seq(input logic [2:0] blk, input logic [7:0] addr, input int n);
    mst.start();
    send({code, blk, 1'b0}, 1'b1);
    send(addr, 1'b1);
    mst.start();
    send({code, blk, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      mst.xbyte(8'hFF, i == n - 1, rx, ak);
      cmp_byte(ebuf[i], rx);
    end
    mst.stop();
  endtask : rd_seq
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_link);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    link_wait(300);
    cmp_bit(1'b0, busy);
    foreach (rows[i]) begin
      ctl(rows[i][7:0], rows[i][8]);
    end
    dbuf[0] = 8'hA5;
    dbuf[1] = 8'h3C;
    ebuf = dbuf;
    wr_seq(imp_pkg::BLK_REG, 8'h3F, 2);
    rd_seq(imp_pkg::BLK_REG, 8'h3F, 2);
    for (int i = 0; i < 16; i++) begin
      dbuf[i] = 8'h40 + 8'(i);
    end
    wr_seq(imp_pkg::BLK_EE, 8'h10, 16);
    wait_busy(1'b1, 200);
    ctl({code, imp_pkg::BLK_EE, 1'b0}, 1'b0);
    ctl({code, imp_pkg::BLK_REG, 1'b0}, 1'b1);
    cmp_bit(1'b1, busy);
    wait_busy(1'b0, PROG + 200);
    link_wait(8);
    ebuf[0] = 8'h4F;
    ebuf[1] = 8'h00;
    rd_seq(imp_pkg::BLK_EE, 8'h1F, 2);
    dbuf[0] = {imp_pkg::ERASE_GO, 1'b1, 4'h1};
    wr_seq(imp_pkg::BLK_REG, imp_pkg::OFS_ERASE, 1);
    wait_busy(1'b1, 200);
    wait_busy(1'b0, PROG + 200);
    link_wait(8);
    ebuf[0] = 8'hFF;
    rd_seq(imp_pkg::BLK_EE, 8'h1F, 2);
    ebuf[0] = 8'h11;
    rd_seq(imp_pkg::BLK_REG, imp_pkg::OFS_ERASE, 1);
    @(posedge clk_sys);
    pins <= 4'hA;
    dbuf[0] = 8'hF1;
    wr_seq(imp_pkg::BLK_REG, imp_pkg::OFS_ADDR_CODE, 1);
    code = 4'hA;
    ctl(8'hA0, 1'b1);
    ctl(8'h10, 1'b0);
    @(posedge clk_sys);
    rstore <= 1'b1;
    link_wait(8);
    cmp_bit(1'b1, rheo_o);
    dbuf[0] = 8'h10;
    wr_seq(imp_pkg::BLK_REG, imp_pkg::OFS_REG_PROT, 1);
    link_wait(8);
    cmp_bit(1'b0, rheo_o);
    ebuf[0] = 8'h10;
    rd_seq(imp_pkg::BLK_REG, imp_pkg::OFS_REG_PROT, 1);
    dbuf[0] = 8'h01;
    wr_seq(imp_pkg::BLK_REG, imp_pkg::OFS_CFG_PROT, 1);
    ctl({code, imp_pkg::BLK_CFG, 1'b1}, 1'b0);
    ctl({code, imp_pkg::BLK_CFG, 1'b0}, 1'b1);
    @(posedge clk_sys);
    reload <= 1'b1;
    link_wait(4);
    @(posedge clk_sys);
    reload <= 1'b0;
    link_wait(300);
    cmp_bit(1'b1, rheo_o);
    code = 4'h1;
    ctl(8'h10, 1'b1);
    ebuf[0] = 8'h00;
    rd_seq(imp_pkg::BLK_REG, imp_pkg::OFS_REG_PROT, 1);
    give_verdict();
  end
endmodule : imp_mtp_access_tb
`default_nettype wire
